/* File: mbpt_pkg.sv */
`default_nettype none
// ************************************************************
// shared constants and types of the match based pwm timer
// ************************************************************
package mbpt_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
	localparam logic [7:0] OFS_TIMER_CTRL = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_PRESCALE = 8'h0C;
	localparam logic [7:0] OFS_PRESCALE_COUNT = 8'h10;
	localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
	localparam logic [7:0] OFS_MATCH_BASE = 8'h18;
	localparam logic [7:0] OFS_CAPTURE_CTRL = 8'h34;
	localparam logic [7:0] OFS_CAPTURE_BASE = 8'h38;
	localparam logic [7:0] OFS_COUNT_CTRL = 8'h48;
	localparam logic [7:0] OFS_PWM_CTRL = 8'h4C;
	localparam logic [7:0] OFS_LATCH_ENABLE = 8'h50;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h54;
	// sizes
	localparam int NUM_MATCH = 7;
	localparam int NUM_CAPTURE = 4;
	localparam int NUM_PWM = 6;
	// status bit layout: match events 0..6, capture events 8..11
	localparam int STAT_CAP_POS = 8;
	// timer control fields
	localparam int TCTRL_ENABLE_POS = 0;
	localparam int TCTRL_RESET_POS = 1;
	localparam int TCTRL_SYNC_POS = 2;
	localparam int TCTRL_PWM_EN_POS = 3;
	// count control field positions
	localparam int CCTRL_MODE_POS = 0;
	localparam int CCTRL_SEL_POS = 2;
	// count modes
	localparam logic [1:0] CMODE_TIMER = 2'h0;
	localparam logic [1:0] CMODE_RISE = 2'h1;
	localparam logic [1:0] CMODE_FALL = 2'h2;
	localparam logic [1:0] CMODE_BOTH = 2'h3;
	// pwm control: bits 2..6 double-edge select, bits 9..14 output enable
	localparam int PCTRL_DOUBLE_POS = 2;
	localparam int PCTRL_OE_POS = 9;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// bus states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} mbpt_bus_e;
	// avalon request bundle
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} mbpt_avreq_s;
endpackage : mbpt_pkg
`default_nettype wire

/* File: mbpt_edge_sync.sv */
`default_nettype none
// ************************************************************
// two-flop synchroniser with edge detection per capture pin
// ************************************************************
module mbpt_edge_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// pins
	input wire logic [mbpt_pkg::NUM_CAPTURE-1:0] pin_in,
	// synchronised edges
	output logic [mbpt_pkg::NUM_CAPTURE-1:0] rise,
	output logic [mbpt_pkg::NUM_CAPTURE-1:0] fall
);
	typedef struct packed {
		logic [mbpt_pkg::NUM_CAPTURE-1:0] meta; // first stage, read only by stage two
		logic [mbpt_pkg::NUM_CAPTURE-1:0] sync; // second stage
		logic [mbpt_pkg::NUM_CAPTURE-1:0] last; // previous synced level
	} mbpt_sync_s;
	mbpt_sync_s st;
	mbpt_sync_s next_st;
	// shift the pins through the stages
	always_comb begin
		next_st.meta = pin_in;
		next_st.sync = st.meta;
		next_st.last = st.sync;
	end
	// register the state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign rise = st.sync & ~st.last;
	assign fall = ~st.sync & st.last;
endmodule // mbpt_edge_sync
`default_nettype wire

/* File: mbpt_timer.sv */
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`default_nettype none
module mbpt_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// capture pins
	input wire logic [mbpt_pkg::NUM_CAPTURE-1:0] capture_pin,
	// run-in-step link: primary drives, secondary listens
	input wire logic sync_start_in,
	output logic sync_start_out,
	// pwm outputs and interrupt
	output logic [mbpt_pkg::NUM_PWM-1:0] pwm_out,
	output logic irq
);
	// ************************************************************
	// state
	// ************************************************************
	localparam int NM = mbpt_pkg::NUM_MATCH;
	localparam int NC = mbpt_pkg::NUM_CAPTURE;
	localparam int NP = mbpt_pkg::NUM_PWM;
	typedef struct packed {
		mbpt_pkg::mbpt_bus_e bus; // bus handshake state
		logic [31:0] rdata; // registered read data
		logic [11:0] status; // sticky event bits
		logic [11:0] mask; // interrupt mask
		logic [3:0] tctrl; // enable, reset, sync-wait, pwm enable
		logic [31:0] count; // timer counter
		logic [31:0] prescale; // prescale limit
		logic [31:0] pcount; // prescale counter
		logic [20:0] mctrl; // per match: irq, reset, stop
		logic [NM*32-1:0] shadow; // software-written match values
		logic [NM*32-1:0] active; // match values in use
		logic [NM-1:0] latch_en; // released shadows waiting for cycle end
		logic [11:0] cctrl; // per capture: rise, fall, irq
		logic [NC*32-1:0] capture; // captured counts
		logic [3:0] count_ctrl; // count mode and capture pin select
		logic [14:0] pctrl; // double-edge select and output enables
		logic [NP-1:0] pwm; // pwm output levels
	} mbpt_state_s;
	mbpt_state_s st;
	mbpt_state_s next_st;
	logic [NC-1:0] cap_rise; // synchronised rising edges
	logic [NC-1:0] cap_fall; // synchronised falling edges
	logic [NM-1:0] hit; // match equal this count
	logic tick; // counter advance enable
	logic run; // counter running
	logic pwm_mode; // pwm mode enabled
	logic edge_src; // selected count edge
	logic [1:0] cmode; // count mode
	logic [1:0] csel; // count source pin
	logic [NP:0] set_ev; // set events per output index 1..6
	logic [NP:0] clr_ev; // clear events per output index 1..6
	// ************************************************************
	// capture pin synchroniser
	// ************************************************************
	mbpt_edge_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(capture_pin),
		.rise(cap_rise),
		.fall(cap_fall)
	);
	// ************************************************************
	// count enable and compare
	// ************************************************************
	assign run = st.tctrl[mbpt_pkg::TCTRL_ENABLE_POS] & ~st.tctrl[mbpt_pkg::TCTRL_RESET_POS];
	assign pwm_mode = st.tctrl[mbpt_pkg::TCTRL_PWM_EN_POS];
	assign cmode = st.count_ctrl[mbpt_pkg::CCTRL_MODE_POS +: 2];
	assign csel = st.count_ctrl[mbpt_pkg::CCTRL_SEL_POS +: 2];
	// select counting edge source
	always_comb begin
		case (cmode)
			mbpt_pkg::CMODE_RISE: edge_src = cap_rise[csel];
			mbpt_pkg::CMODE_FALL: edge_src = cap_fall[csel];
			mbpt_pkg::CMODE_BOTH: edge_src = cap_rise[csel] | cap_fall[csel];
			default: edge_src = 1'b1;
		endcase
	end
	// prescaler terminal count gives one tick
	assign tick = run & edge_src & (st.pcount == st.prescale);
	// compare every match in parallel
	genvar gi;
	generate
		for (gi = 0; gi < NM; gi++) begin : g_cmp
			assign hit[gi] = tick & (st.count == st.active[gi*32 +: 32]);
		end
	endgenerate
	// set and clear events for each pwm output
	generate
		for (gi = 1; gi <= NP; gi++) begin : g_pwm
			if (gi == 1) begin : g_single
				assign set_ev[gi] = hit[0];
			end else begin : g_dual
				// double-edge rises on the previous match
				assign set_ev[gi] = st.pctrl[mbpt_pkg::PCTRL_DOUBLE_POS + gi - 2]
					? hit[gi-1] : hit[0];
			end
			assign clr_ev[gi] = hit[gi];
		end
	endgenerate
	assign set_ev[0] = 1'b0;
	assign clr_ev[0] = 1'b0;
	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [11:0] ev;
		logic [31:0] wmask;
		logic wr_ok;
		logic rd_ok;
		logic do_reset;
		logic do_stop;
		ev = '0;
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wr_ok = 1'b0;
		rd_ok = 1'b0;
		do_reset = 1'b0;
		do_stop = 1'b0;
		next_st = st;
		next_st.rdata = st.rdata;
		// match actions, all handled together
		for (int i = 0; i < NM; i++) begin
			if (hit[i]) begin
				ev[i] = st.mctrl[i*3];
				do_reset = do_reset | st.mctrl[i*3+1];
				do_stop = do_stop | st.mctrl[i*3+2];
			end
		end
		// in pwm mode the cycle-rate match always restarts the counter
		if (pwm_mode && hit[0]) begin
			do_reset = 1'b1;
		end
		// prescaler and counter
		if (run && edge_src) begin
			if (st.pcount == st.prescale) begin
				next_st.pcount = mbpt_pkg::RST_ZERO;
				next_st.count = do_reset ? mbpt_pkg::RST_ZERO : st.count + 32'h0000_0001;
			end else begin
				next_st.pcount = st.pcount + 32'h0000_0001;
			end
		end
		if (do_stop) begin
			next_st.tctrl[mbpt_pkg::TCTRL_ENABLE_POS] = 1'b0;
		end
		// released match values take over at the cycle start only
		if (hit[0] && pwm_mode) begin
			for (int i = 0; i < NM; i++) begin
				if (st.latch_en[i]) begin
					next_st.active[i*32 +: 32] = st.shadow[i*32 +: 32];
				end
			end
			next_st.latch_en = '0;
		end
		// pwm outputs: clear wins over set, so equal positions give low
		for (int i = 1; i <= NP; i++) begin
			if (!pwm_mode) begin
				next_st.pwm[i-1] = 1'b0;
			end else if (clr_ev[i]) begin
				next_st.pwm[i-1] = 1'b0;
			end else if (set_ev[i]) begin
				next_st.pwm[i-1] = 1'b1;
			end
		end
		// capture on selected pin edges
		for (int i = 0; i < NC; i++) begin
			if ((cap_rise[i] && st.cctrl[i*3]) || (cap_fall[i] && st.cctrl[i*3+1])) begin
				next_st.capture[i*32 +: 32] = st.count;
				ev[mbpt_pkg::STAT_CAP_POS + i] = st.cctrl[i*3+2];
			end
		end
		// secondary unit starts once the primary's enable level is high
		if (st.tctrl[mbpt_pkg::TCTRL_SYNC_POS] && sync_start_in) begin
			next_st.tctrl[mbpt_pkg::TCTRL_ENABLE_POS] = 1'b1;
			next_st.tctrl[mbpt_pkg::TCTRL_SYNC_POS] = 1'b0;
		end
		// avalon-mm slave: one wait cycle, answer in the next
		case (st.bus)
			mbpt_pkg::BUS_IDLE: begin
				if (avs_read || avs_write) begin
					next_st.bus = mbpt_pkg::BUS_DONE;
					rd_ok = avs_read;
				end
			end
			// a write lands only at the edge where waitrequest is low
			mbpt_pkg::BUS_DONE: begin
				next_st.bus = mbpt_pkg::BUS_IDLE;
				wr_ok = avs_write;
			end
			default: begin
				next_st.bus = mbpt_pkg::BUS_IDLE;
			end
		endcase
		if (rd_ok) begin
			next_st.rdata = 32'h0000_0000;
			case (avs_address)
				mbpt_pkg::OFS_IRQ_STATUS: next_st.rdata = {20'h0_0000, st.status};
				mbpt_pkg::OFS_TIMER_CTRL: next_st.rdata = {28'h000_0000, st.tctrl};
				mbpt_pkg::OFS_COUNT: next_st.rdata = st.count;
				mbpt_pkg::OFS_PRESCALE: next_st.rdata = st.prescale;
				mbpt_pkg::OFS_PRESCALE_COUNT: next_st.rdata = st.pcount;
				mbpt_pkg::OFS_MATCH_CTRL: next_st.rdata = {11'h000, st.mctrl};
				mbpt_pkg::OFS_CAPTURE_CTRL: next_st.rdata = {20'h0_0000, st.cctrl};
				mbpt_pkg::OFS_COUNT_CTRL: next_st.rdata = {28'h000_0000, st.count_ctrl};
				mbpt_pkg::OFS_PWM_CTRL: next_st.rdata = {17'h0_0000, st.pctrl};
				mbpt_pkg::OFS_LATCH_ENABLE: next_st.rdata = {25'h000_0000, st.latch_en};
				mbpt_pkg::OFS_IRQ_MASK: next_st.rdata = {20'h0_0000, st.mask};
				default: begin
					for (int i = 0; i < NM; i++) begin
						if (avs_address == mbpt_pkg::OFS_MATCH_BASE + 8'(4 * i)) begin
							next_st.rdata = st.shadow[i*32 +: 32];
						end
					end
					for (int i = 0; i < NC; i++) begin
						if (avs_address == mbpt_pkg::OFS_CAPTURE_BASE + 8'(4 * i)) begin
							next_st.rdata = st.capture[i*32 +: 32];
						end
					end
				end
			endcase
		end
		// status: write one clears, a new event wins
		next_st.status = st.status;
		if (wr_ok && avs_address == mbpt_pkg::OFS_IRQ_STATUS) begin
			next_st.status = st.status & ~avs_writedata[11:0];
		end
		next_st.status = next_st.status | ev;
		if (wr_ok) begin
			case (avs_address)
				mbpt_pkg::OFS_TIMER_CTRL: begin
					next_st.tctrl = (st.tctrl & ~wmask[3:0]) | (avs_writedata[3:0] & wmask[3:0]);
					// a written reset bit also clears the counter and the prescale counter
					if (avs_writedata[mbpt_pkg::TCTRL_RESET_POS]) begin
						next_st.count = mbpt_pkg::RST_ZERO;
						next_st.pcount = mbpt_pkg::RST_ZERO;
					end
				end
				mbpt_pkg::OFS_COUNT: next_st.count = (st.count & ~wmask) | (avs_writedata & wmask);
				mbpt_pkg::OFS_PRESCALE: next_st.prescale = (st.prescale & ~wmask)
					| (avs_writedata & wmask);
				mbpt_pkg::OFS_MATCH_CTRL: next_st.mctrl = avs_writedata[20:0];
				mbpt_pkg::OFS_CAPTURE_CTRL: next_st.cctrl = avs_writedata[11:0];
				mbpt_pkg::OFS_COUNT_CTRL: next_st.count_ctrl = avs_writedata[3:0];
				mbpt_pkg::OFS_PWM_CTRL: next_st.pctrl = avs_writedata[14:0];
				// keep the cycle-start clear of bits already applied
				mbpt_pkg::OFS_LATCH_ENABLE: next_st.latch_en = next_st.latch_en
					| avs_writedata[NM-1:0];
				mbpt_pkg::OFS_IRQ_MASK: next_st.mask = avs_writedata[11:0];
				default: begin
					for (int i = 0; i < NM; i++) begin
						if (avs_address == mbpt_pkg::OFS_MATCH_BASE + 8'(4 * i)) begin
							next_st.shadow[i*32 +: 32] = (st.shadow[i*32 +: 32] & ~wmask)
								| (avs_writedata & wmask);
							// outside pwm mode a written match applies at once
							if (!pwm_mode) begin
								next_st.active[i*32 +: 32] = (st.shadow[i*32 +: 32] & ~wmask)
									| (avs_writedata & wmask);
							end
						end
					end
				end
			endcase
		end
	end
	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.bus <= mbpt_pkg::BUS_IDLE;
		end else begin
			st <= next_st;
		end
	end
	// ************************************************************
	// outputs
	// ************************************************************
	assign avs_waitrequest = (avs_read | avs_write) & (st.bus != mbpt_pkg::BUS_DONE);
	assign avs_readdata = st.rdata;
	assign pwm_out = st.pwm & st.pctrl[mbpt_pkg::PCTRL_OE_POS +: NP];
	assign irq = |(st.status & st.mask);
	// enable as seen by a partner unit, from a register
	assign sync_start_out = st.tctrl[mbpt_pkg::TCTRL_ENABLE_POS];
endmodule // mbpt_timer
`default_nettype wire

/* File: mbpt_chk.sv */
`default_nettype none
// ************************************************************
// port checker of the match based pwm timer
// ************************************************************
module mbpt_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// outputs
	input wire logic sync_start_out,
	input wire logic [5:0] pwm_out,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic pwm_on; // pwm mode bit as last written
	logic [5:0] oe; // output enables as last written
	logic mask_any; // some mask bit written as one
	wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF; // accepted write
	// shadow of the control bits that the outputs hang on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_on <= 1'b0;
			oe <= 6'h00;
			mask_any <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address == mbpt_pkg::OFS_TIMER_CTRL) pwm_on <= avs_writedata[3];
			if (avs_address == mbpt_pkg::OFS_PWM_CTRL) oe <= avs_writedata[14:9];
			if (avs_address == mbpt_pkg::OFS_IRQ_MASK) mask_any <= |avs_writedata;
		end
	end
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ctrl_wr; wr_ok && avs_address == mbpt_pkg::OFS_TIMER_CTRL; endsequence
	property p_wait_one; s_req |=> !avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer late");
	property p_wait_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("stall while idle");
	property p_wait_first;
		(avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address >= 8'h58 |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rd_stand; !avs_read && !$past(avs_read) |-> $stable(avs_readdata); endproperty
	a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
	property p_sync; s_ctrl_wr |=> sync_start_out == $past(avs_writedata[0]); endproperty
	a_sync: assert property (p_sync) else $error("step link not enable");
	property p_oe_low; (pwm_out & ~oe & ~$past(oe) & ~$past(oe, 2)) == 6'h00; endproperty
	a_oe_low: assert property (p_oe_low) else $error("disabled output high");
	property p_pwm_off;
		!pwm_on && !$past(pwm_on) && !$past(pwm_on, 2) |-> $stable(pwm_out);
	endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("waveform outside pwm mode");
	property p_irq_off; !mask_any && !$past(mask_any) |-> !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked interrupt seen");
endmodule // mbpt_chk
bind mbpt_timer mbpt_chk u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.sync_start_out(sync_start_out), .pwm_out(pwm_out), .irq(irq)
);
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
// ************************************************************
// self-checking bench of the match based pwm timer
// ************************************************************
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0; // 125 MHz clock
	logic rst_n = 1'b0; // reset, held at start
	mbpt_pkg::mbpt_avreq_s req = '0; // bench bus request
	logic [31:0] avs_readdata; // read data
	logic avs_waitrequest; // slave stall
	logic [1:0] cap = 2'h0; // capture pins in use
	logic sync_start_out; // step link out
	logic sync_in = 1'b0; // step link in, driven by the bench
	logic [5:0] pwm_out; // waveforms
	logic irq; // interrupt
	logic [31:0] seed = 32'h2; // xorshift state
	logic [31:0] rd; // last read data
	logic [31:0] v; // random value
	int errors = 0; // mismatches
	int check_count = 0; // comparisons
	int cycles = 0; // hang limit counter
	int n; // pulse count
	int hi [6]; // high cycles per output
	int rise [6]; // rising edges per output
	int mv [4] = '{19, 5, 12, 3}; // cycle rate and edge positions
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	mbpt_timer uut (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(req.address), .avs_read(req.read),
		.avs_write(req.write), .avs_writedata(req.writedata), .avs_byteenable(req.byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.capture_pin({2'h0, cap}), .sync_start_in(sync_in), .sync_start_out(sync_start_out),
		.pwm_out(pwm_out), .irq(irq)
	);
	// hang limit
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			end_of_test();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// high counts per cycle of mv[0]+1 counts, set at match r and cleared at match f
	function automatic int hgh(input int r, input int f);
		return (f > r) ? f - r : mv[0] + 1 - r + f;
	endfunction
	// counted edges for a count mode
	function automatic int edges(input int m, input int p);
		return (m == int'(mbpt_pkg::CMODE_BOTH)) ? 2 * p : p;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
		// only the bench's hang limit ends this wait
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		req <= '0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// restart the counter from zero with the given control
	task automatic run(input logic [31:0] c);
		wr(mbpt_pkg::OFS_TIMER_CTRL, 32'h2);
		wr(mbpt_pkg::OFS_TIMER_CTRL, c);
	endtask
	task automatic pulse(input int b);
		cap[b] <= 1'b1;
		repeat (6) @(posedge core_clk);
		cap[b] <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic meas(input int c);
		logic [5:0] prev;
		prev = pwm_out;
		hi = '{default: 0};
		rise = '{default: 0};
		repeat (c) begin
			@(posedge core_clk);
			foreach (hi[k]) hi[k] += pwm_out[k];
			foreach (rise[k]) rise[k] += pwm_out[k] & ~prev[k];
			prev = pwm_out;
		end
	endtask
	// ten cycles of the three enabled outputs, the rest held low
	task automatic pwm_chk(input int m1);
		int e [6];
		// the single-edge output rises on the cycle-rate match
		e = '{hgh(mv[0], m1), hgh(m1, 12), hgh(12, 3), 0, 0, 0};
		repeat (40) @(posedge core_clk);
		meas(200);
		foreach (e[k]) chk(hi[k], 10 * e[k]);
		foreach (e[k]) chk(rise[k], (k < 3) ? 10 : 0);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int a = 0; a < 'h5C; a += 4) rc(8'(a), mbpt_pkg::RST_ZERO);
		wr(8'h58, rnd());
		rc(8'h58, 32'h0);
		v = rnd();
		wr(mbpt_pkg::OFS_PRESCALE, v);
		rc(mbpt_pkg::OFS_PRESCALE, v);
		for (int i = 0; i < mbpt_pkg::NUM_MATCH; i++) begin
			v = rnd();
			wr(8'(mbpt_pkg::OFS_MATCH_BASE + 4 * i), v);
			rc(8'(mbpt_pkg::OFS_MATCH_BASE + 4 * i), v);
		end
		// stop on match one with interrupt
		wr(mbpt_pkg::OFS_PRESCALE, 32'h2);
		wr(mbpt_pkg::OFS_MATCH_BASE + 8'h04, 32'h14);
		wr(mbpt_pkg::OFS_MATCH_CTRL, 32'h28);
		run(32'h1);
		repeat (150) @(posedge core_clk);
		// the matching count still advances once before the stop holds it
		rc(mbpt_pkg::OFS_COUNT, 32'h15);
		rc(mbpt_pkg::OFS_IRQ_STATUS, 32'h2);
		chk(32'(irq), 32'h0);
		wr(mbpt_pkg::OFS_IRQ_MASK, 32'h2);
		chk(32'(irq), 32'h1);
		wr(mbpt_pkg::OFS_IRQ_STATUS, 32'h2);
		chk(32'(irq), 32'h0);
		// reset on the cycle-rate match
		wr(mbpt_pkg::OFS_MATCH_CTRL, 32'h2);
		wr(mbpt_pkg::OFS_MATCH_BASE, 32'h9);
		wr(mbpt_pkg::OFS_PRESCALE, 32'h0);
		run(32'h1);
		repeat (8) begin
			bus(1'b0, mbpt_pkg::OFS_COUNT, 32'h0);
			chk(32'(rd <= 32'h9), 32'h1);
		end
		// single, positive and negative double edge outputs
		wr(mbpt_pkg::OFS_MATCH_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) wr(8'(mbpt_pkg::OFS_MATCH_BASE + 4 * i), 32'(mv[i]));
		wr(mbpt_pkg::OFS_PWM_CTRL, 32'h0E0C);
		wr(mbpt_pkg::OFS_LATCH_ENABLE, 32'h0F);
		run(32'h9);
		pwm_chk(5);
		wr(mbpt_pkg::OFS_MATCH_BASE + 8'h04, 32'hA);
		pwm_chk(5);
		wr(mbpt_pkg::OFS_LATCH_ENABLE, 32'h2);
		pwm_chk(10);
		wr(mbpt_pkg::OFS_TIMER_CTRL, 32'h1);
		meas(100);
		foreach (rise[k]) chk(rise[k], 0);
		// counter mode on each edge kind of pin zero
		for (int m = 1; m < 4; m++) begin
			wr(mbpt_pkg::OFS_COUNT_CTRL, 32'(m));
			run(32'h1);
			n = 2 + int'(rnd() % 4);
			repeat (n) pulse(0);
			rc(mbpt_pkg::OFS_COUNT, edges(m, n));
		end
		// capture of a stopped count on pin one
		wr(mbpt_pkg::OFS_TIMER_CTRL, 32'h0);
		wr(mbpt_pkg::OFS_COUNT_CTRL, 32'h0);
		v = rnd();
		wr(mbpt_pkg::OFS_COUNT, v);
		wr(mbpt_pkg::OFS_IRQ_STATUS, 32'hFFF);
		wr(mbpt_pkg::OFS_CAPTURE_CTRL, 32'h28);
		pulse(1);
		rc(mbpt_pkg::OFS_CAPTURE_BASE + 8'h04, v);
		rc(mbpt_pkg::OFS_IRQ_STATUS, 32'h200);
		// secondary start: wait for the partner's enable, then run
		wr(mbpt_pkg::OFS_TIMER_CTRL, 32'h4);
		chk(32'(sync_start_out), 32'h0);
		rc(mbpt_pkg::OFS_COUNT, v);
		sync_in <= 1'b1;
		@(posedge core_clk);
		sync_in <= 1'b0;
		rc(mbpt_pkg::OFS_TIMER_CTRL, 32'h1);
		chk(32'(sync_start_out), 32'h1);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
